//--- rtcp_pkg.sv
// Shared constants of the real-time counter with periodic timer.
// Assumes byte addresses equal four times the register index.
package rtcp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] CTRL_IDX = 6'h00;
  localparam logic [5:0] STATUS_IDX = 6'h01;
  localparam logic [5:0] IRQ_ENABLE_IDX = 6'h02;
  localparam logic [5:0] IRQ_FLAGS_IDX = 6'h03;
  localparam logic [5:0] CALIBRATION_IDX = 6'h06;
  localparam logic [5:0] SOURCE_SELECT_IDX = 6'h07;
  localparam logic [5:0] COUNT_IDX = 6'h08;
  localparam logic [5:0] PERIOD_LIMIT_IDX = 6'h0a;
  localparam logic [5:0] COMPARE_IDX = 6'h0c;
  localparam logic [5:0] PERIODIC_CTRL_IDX = 6'h10;
  localparam logic [5:0] PERIODIC_STATUS_IDX = 6'h11;
  localparam logic [5:0] PERIODIC_IRQ_ENABLE_IDX = 6'h12;
  localparam logic [5:0] PERIODIC_IRQ_FLAGS_IDX = 6'h13;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CORRECTION_BIT = 2;
  localparam int CTRL_PRESCALER_LSB = 3;
  localparam int PERIODIC_ENABLE_BIT = 0;
  localparam int PERIODIC_PERIOD_LSB = 3;
  localparam int FLAG_OVERFLOW_BIT = 0;
  localparam int FLAG_COMPARE_BIT = 1;
  localparam int CAL_SIGN_BIT = 7;

  // Reset values
  localparam logic [15:0] PERIOD_LIMIT_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] CAL_RESET = 8'h00;

  // Counter clock source codes
  localparam logic [1:0] SRC_INTERNAL_OSC = 2'h0;
  localparam logic [1:0] SRC_INTERNAL_DIV = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL = 2'h3;
  localparam logic [4:0] OSC_DIV_LAST = 5'h1f;

  // Correction interval, in prescaler input cycles
  localparam logic [19:0] CORR_INTERVAL = 20'h0f4240;
  localparam logic [19:0] CORR_INTERVAL_LAST = 20'h0f423f;

  // Event divider taps: first event is prescaler bit 5 (divide by 64)
  localparam int EVENT_TAP_LSB = 5;
  localparam int EVENT_COUNT = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtcp_prescaler.sv
// Shared 15-bit prescaler with crystal error correction.
// Assumes srcTick is a one-cycle pulse per counter clock period.
`timescale 1ns/1ps
`default_nettype none
module rtcp_prescaler (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control
  input wire logic srcTick,
  input wire logic run,
  input wire logic correctionEnable,
  input wire logic [7:0] crystalCalibration,
  input wire logic [3:0] prescSel,
  // Results
  output logic [14:0] prescCount,
  output logic counterTick
);

  typedef struct packed {
    logic [14:0] presc;
    logic [19:0] interval;
    logic [19:0] acc;
    logic active;
    logic negative;
    logic [6:0] err;
  } rtcp_presc_state_t;

  rtcp_presc_state_t s_q, s_d;
  logic [1:0] step;
  logic [15:0] mask;
  logic [20:0] accSum;
  logic corrNow;

  always_comb begin
    s_d = s_q;
    mask = (16'h0001 << prescSel) - 16'h0001;
    accSum = {1'b0, s_q.acc} + {14'h0000, s_q.err};
    corrNow = s_q.active && (accSum >= {1'b0, rtcp_pkg::CORR_INTERVAL});
    step = 2'h1;
    if (corrNow) begin
      step = s_q.negative ? 2'h2 : 2'h0;
    end
    counterTick = 1'b0;
    if (srcTick && run) begin
      s_d.presc = s_q.presc + {13'h0000, step};
      counterTick = ({1'b0, s_q.presc & mask[14:0]} + {14'h0000, step}) > mask;
      s_d.acc = corrNow ? 20'(accSum - {1'b0, rtcp_pkg::CORR_INTERVAL}) : accSum[19:0];
      if (s_q.interval == rtcp_pkg::CORR_INTERVAL_LAST) begin
        // Enable and error are only taken at interval boundaries
        s_d.interval = 20'h00000;
        s_d.acc = 20'h00000;
        s_d.active = correctionEnable;
        s_d.negative = crystalCalibration[rtcp_pkg::CAL_SIGN_BIT];
        s_d.err = crystalCalibration[6:0];
      end else begin
        s_d.interval = s_q.interval + 20'h00001;
      end
    end
    prescCount = s_q.presc;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // rtcp_prescaler
`default_nettype wire

//--- rtcp_counter.sv
// Real-time counter and periodic timer with an AXI4-Lite register slave.
// Assumes clock source inputs are levels synchronous to core_clk.
//
// What this block does
// - Compare flag and event after matching count.
// - Period match: overflow flag, event, wrap zero.
// - Four selectable counter clock sources.
// - 15-bit prescaler output advances the counter.
// - Correction spreads error cycles per million.
// - Speed up skips, slow down inserts counts.
// - Finish ongoing correction interval before stopping.
// - Count and periodic intervals include correction.
// - Periodic interrupt every power-of-two periods.
// - Eight level events, prescaler divided 64..8192.
// - Events pulse one counter period, same conditions.
// - Shared prescaler runs if either enabled.
// - First tick may take up to period.
// - Periodic output toggles every half period.
// - Counter enable bit starts and stops counter.
// - Periodic enable bit starts and stops timer.
// - Request held while enable and flag set.
`timescale 1ns/1ps
`default_nettype none
module rtcp_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Counter clock sources
  input wire logic crystalClk,
  input wire logic externalClk,
  input wire logic internalOscClk,
  // Events and interrupt requests
  output logic overflowWrapEvent,
  output logic compareMatchEvent,
  output logic [7:0] periodicDivEvent,
  output logic counterIrq,
  output logic periodicIrq
);

  typedef struct packed {
    logic awFull;
    logic [5:0] awIdx;
    logic wFull;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic counterEnable;
    logic correctionEnable;
    logic [3:0] prescSel;
    logic [1:0] irqEnable;
    logic [1:0] flags;
    logic [7:0] calibration;
    logic [1:0] srcSel;
    logic [15:0] countValue;
    logic [15:0] periodLimit;
    logic [15:0] compareValue;
    logic periodicEnable;
    logic [3:0] periodicPeriod;
    logic periodicIrqEnable;
    logic periodicFlag;
    logic [2:0] srcPrev;
    logic [4:0] oscDiv;
    logic srcTick;
    logic periodicLevelPrev;
    logic overflowEvent;
    logic compareEvent;
    logic [7:0] divEvent;
    logic counterIrq;
    logic periodicIrq;
  } rtcp_state_t;

  rtcp_state_t s_q, s_d;
  logic [14:0] prescCount;
  logic counterTick;
  logic periodicLevel;
  logic writeNow;
  logic [5:0] arIdx;

  // Byte-lane merge, used by the count, period limit and compare writes
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  // Index of a mapped register
  function automatic logic isMapped(input logic [5:0] idx);
    case (idx)
      rtcp_pkg::CTRL_IDX, rtcp_pkg::STATUS_IDX, rtcp_pkg::IRQ_ENABLE_IDX,
      rtcp_pkg::IRQ_FLAGS_IDX, rtcp_pkg::CALIBRATION_IDX, rtcp_pkg::SOURCE_SELECT_IDX,
      rtcp_pkg::COUNT_IDX, rtcp_pkg::PERIOD_LIMIT_IDX, rtcp_pkg::COMPARE_IDX,
      rtcp_pkg::PERIODIC_CTRL_IDX, rtcp_pkg::PERIODIC_STATUS_IDX,
      rtcp_pkg::PERIODIC_IRQ_ENABLE_IDX, rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  rtcp_prescaler u_prescaler (
    .core_clk(core_clk),
    .resetn(resetn),
    .srcTick(s_q.srcTick),
    .run(s_q.counterEnable || s_q.periodicEnable),
    .correctionEnable(s_q.correctionEnable),
    .crystalCalibration(s_q.calibration),
    .prescSel(s_q.prescSel),
    .prescCount(prescCount),
    .counterTick(counterTick)
  );

  // Periodic output: prescaler bit k for a period of 2^(k+1), off at 0 and 15
  always_comb begin
    periodicLevel = 1'b0;
    if (s_q.periodicPeriod != 4'h0 && s_q.periodicPeriod != 4'hf) begin
      periodicLevel = prescCount[s_q.periodicPeriod];
    end
  end

  assign arIdx = s_axi_araddr[7:2];
  assign writeNow = s_q.awFull && s_q.wFull && !s_q.bValid;

  always_comb begin
    s_d = s_q;

    ////////////////////////////////////////////////////////////////////////
    // Counter clock source select
    s_d.srcPrev = {crystalClk, externalClk, internalOscClk};
    s_d.srcTick = 1'b0;
    if (internalOscClk && !s_q.srcPrev[0]) begin
      s_d.oscDiv = s_q.oscDiv + 5'h01;
    end
    unique case (s_q.srcSel)
      rtcp_pkg::SRC_INTERNAL_OSC: s_d.srcTick = internalOscClk && !s_q.srcPrev[0];
      rtcp_pkg::SRC_INTERNAL_DIV: begin
        s_d.srcTick = internalOscClk && !s_q.srcPrev[0] &&
                      (s_q.oscDiv == rtcp_pkg::OSC_DIV_LAST);
      end
      rtcp_pkg::SRC_EXTERNAL: s_d.srcTick = externalClk && !s_q.srcPrev[1];
      rtcp_pkg::SRC_CRYSTAL: s_d.srcTick = crystalClk && !s_q.srcPrev[2];
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Events last one counter clock period
    if (s_q.srcTick) begin
      s_d.overflowEvent = 1'b0;
      s_d.compareEvent = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    s_d.bValid = s_q.bValid && !s_axi_bready;
    if (writeNow) begin
      s_d.awFull = 1'b0;
      s_d.wFull = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = isMapped(s_q.awIdx) ? rtcp_pkg::RESP_OKAY : rtcp_pkg::RESP_SLVERR;
      case (s_q.awIdx)
        rtcp_pkg::CTRL_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.counterEnable = s_q.wData[rtcp_pkg::CTRL_ENABLE_BIT];
            s_d.correctionEnable = s_q.wData[rtcp_pkg::CTRL_CORRECTION_BIT];
            s_d.prescSel = s_q.wData[rtcp_pkg::CTRL_PRESCALER_LSB +: 4];
          end
        end
        rtcp_pkg::IRQ_ENABLE_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.irqEnable = s_q.wData[1:0];
          end
        end
        rtcp_pkg::IRQ_FLAGS_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.flags = s_q.flags & ~s_q.wData[1:0];
          end
        end
        rtcp_pkg::CALIBRATION_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.calibration = s_q.wData[7:0];
          end
        end
        rtcp_pkg::SOURCE_SELECT_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.srcSel = s_q.wData[1:0];
          end
        end
        rtcp_pkg::COUNT_IDX: s_d.countValue = laneMerge(s_q.countValue, s_q.wData, s_q.wStrb);
        rtcp_pkg::PERIOD_LIMIT_IDX: begin
          s_d.periodLimit = laneMerge(s_q.periodLimit, s_q.wData, s_q.wStrb);
        end
        rtcp_pkg::COMPARE_IDX: begin
          s_d.compareValue = laneMerge(s_q.compareValue, s_q.wData, s_q.wStrb);
        end
        rtcp_pkg::PERIODIC_CTRL_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.periodicEnable = s_q.wData[rtcp_pkg::PERIODIC_ENABLE_BIT];
            s_d.periodicPeriod = s_q.wData[rtcp_pkg::PERIODIC_PERIOD_LSB +: 4];
          end
        end
        rtcp_pkg::PERIODIC_IRQ_ENABLE_IDX: begin
          if (s_q.wStrb[0]) begin
            s_d.periodicIrqEnable = s_q.wData[0];
          end
        end
        rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX: begin
          if (s_q.wStrb[0] && s_q.wData[0]) begin
            s_d.periodicFlag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (s_axi_awvalid && s_q.awReady) begin
      s_d.awFull = 1'b1;
      s_d.awIdx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_q.wReady) begin
      s_d.wFull = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    s_d.awReady = !s_d.awFull;
    s_d.wReady = !s_d.wFull;

    ////////////////////////////////////////////////////////////////////////
    // Counter: tick after a match sets its flag and event; a period match also wraps
    if (counterTick && s_q.counterEnable) begin
      if (s_q.countValue == s_q.periodLimit) begin
        s_d.countValue = 16'h0000;
        s_d.flags[rtcp_pkg::FLAG_OVERFLOW_BIT] = 1'b1;
        s_d.overflowEvent = 1'b1;
      end else begin
        s_d.countValue = s_q.countValue + 16'h0001;
      end
      if (s_q.countValue == s_q.compareValue) begin
        s_d.flags[rtcp_pkg::FLAG_COMPARE_BIT] = 1'b1;
        s_d.compareEvent = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Periodic timer: rising edge of the divided level sets its flag
    s_d.periodicLevelPrev = periodicLevel;
    if (s_q.periodicEnable && periodicLevel && !s_q.periodicLevelPrev) begin
      s_d.periodicFlag = 1'b1;
    end
    for (int i = 0; i < rtcp_pkg::EVENT_COUNT; i++) begin
      s_d.divEvent[i] = prescCount[rtcp_pkg::EVENT_TAP_LSB + i] && s_q.periodicEnable;
    end

    // Requests stand while enable and flag are both set
    s_d.counterIrq = |(s_d.flags & s_d.irqEnable);
    s_d.periodicIrq = s_d.periodicFlag && s_d.periodicIrqEnable;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    s_d.rValid = s_q.rValid && !s_axi_rready;
    if (s_axi_arvalid && s_q.arReady) begin
      s_d.rValid = 1'b1;
      s_d.rResp = isMapped(arIdx) ? rtcp_pkg::RESP_OKAY : rtcp_pkg::RESP_SLVERR;
      s_d.rData = 32'h00000000;
      case (arIdx)
        rtcp_pkg::CTRL_IDX: begin
          s_d.rData[rtcp_pkg::CTRL_ENABLE_BIT] = s_q.counterEnable;
          s_d.rData[rtcp_pkg::CTRL_CORRECTION_BIT] = s_q.correctionEnable;
          s_d.rData[rtcp_pkg::CTRL_PRESCALER_LSB +: 4] = s_q.prescSel;
        end
        rtcp_pkg::IRQ_ENABLE_IDX: s_d.rData[1:0] = s_q.irqEnable;
        rtcp_pkg::IRQ_FLAGS_IDX: s_d.rData[1:0] = s_q.flags;
        rtcp_pkg::CALIBRATION_IDX: s_d.rData[7:0] = s_q.calibration;
        rtcp_pkg::SOURCE_SELECT_IDX: s_d.rData[1:0] = s_q.srcSel;
        rtcp_pkg::COUNT_IDX: s_d.rData[15:0] = s_q.countValue;
        rtcp_pkg::PERIOD_LIMIT_IDX: s_d.rData[15:0] = s_q.periodLimit;
        rtcp_pkg::COMPARE_IDX: s_d.rData[15:0] = s_q.compareValue;
        rtcp_pkg::PERIODIC_CTRL_IDX: begin
          s_d.rData[rtcp_pkg::PERIODIC_ENABLE_BIT] = s_q.periodicEnable;
          s_d.rData[rtcp_pkg::PERIODIC_PERIOD_LSB +: 4] = s_q.periodicPeriod;
        end
        rtcp_pkg::PERIODIC_IRQ_ENABLE_IDX: s_d.rData[0] = s_q.periodicIrqEnable;
        rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX: s_d.rData[0] = s_q.periodicFlag;
        default: s_d.rData = 32'h00000000;
      endcase
    end
    s_d.arReady = !s_d.rValid;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.awReady <= 1'b1;
      s_q.wReady <= 1'b1;
      s_q.arReady <= 1'b1;
      s_q.periodLimit <= rtcp_pkg::PERIOD_LIMIT_RESET;
      s_q.countValue <= rtcp_pkg::COUNT_RESET;
      s_q.compareValue <= rtcp_pkg::COMPARE_RESET;
      s_q.calibration <= rtcp_pkg::CAL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready = s_q.wReady;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rresp = s_q.rResp;
  assign s_axi_rdata = s_q.rData;
  assign overflowWrapEvent = s_q.overflowEvent;
  assign compareMatchEvent = s_q.compareEvent;
  assign periodicDivEvent = s_q.divEvent;
  assign counterIrq = s_q.counterIrq;
  assign periodicIrq = s_q.periodicIrq;

endmodule // rtcp_counter
`default_nettype wire

//--- rtcp_counter_properties.sv
// Port checker for the counter block.
// Assumes it is bound to rtcp_counter.
`timescale 1ns/1ps
`default_nettype none
module rtcp_counter_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Events and requests
  input wire logic overflowWrapEvent,
  input wire logic compareMatchEvent,
  input wire logic [7:0] periodicDivEvent,
  input wire logic counterIrq,
  input wire logic periodicIrq
);
  logic [2:0] sinceWrite_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Cycles since the last accepted write address
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sinceWrite_q <= 3'h7;
    end else if (s_axi_awvalid && s_axi_awready) begin
      sinceWrite_q <= 3'h0;
    end else if (sinceWrite_q != 3'h7) begin
      sinceWrite_q <= sinceWrite_q + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_wrap_pulse: assert property (
    $rose(overflowWrapEvent) |=> overflowWrapEvent) else $error("overflow pulse too short");
  a_match_pulse: assert property (
    $rose(compareMatchEvent) |=> compareMatchEvent) else $error("compare pulse too short");
  a_cirq_drop_cause: assert property (
    $fell(counterIrq) |-> sinceWrite_q < 3'h6) else $error("counter request dropped alone");
  a_pirq_drop_cause: assert property (
    $fell(periodicIrq) |-> sinceWrite_q < 3'h6) else $error("periodic request dropped alone");
  a_div_event_ripple: assert property (
    $rose(periodicDivEvent[1]) |-> $fell(periodicDivEvent[0]) || $past(periodicDivEvent) == 8'h00)
    else $error("divided event out of order");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data missing");
  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_read_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while busy");
endmodule // rtcp_counter_checker

bind rtcp_counter rtcp_counter_checker i_checker (.core_clk, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .overflowWrapEvent, .compareMatchEvent, .periodicDivEvent, .counterIrq, .periodicIrq);
`default_nettype wire

//--- rtcp_source_model.sv
// Counter clock sources seen by the block.
// Assumes levels change right after core_clk edges.
`timescale 1ns/1ps
`default_nettype none
module rtcp_source_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Counter clock sources
  output logic internalOscClk,
  output logic crystalClk,
  output logic externalClk
);
  logic [4:0] phase_q;

  // Periods of 4, 8 and 12 core cycles; fastest is a quarter of core_clk
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 5'h00;
    end else begin
      phase_q <= (phase_q == 5'h17) ? 5'h00 : phase_q + 5'h01;
    end
  end
  assign internalOscClk = phase_q[1];
  assign crystalClk = phase_q[2];
  assign externalClk = (phase_q % 5'h0c) < 5'h06;
endmodule // rtcp_source_model
`default_nettype wire

//--- rtcp_counter_tb.sv
// Self-checking bench for the counter block.
// Assumes the source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module rtcp_counter_tb;
  logic core_clk, resetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic crystalClk, externalClk, internalOscClk, overflowWrapEvent, compareMatchEvent;
  logic counterIrq, periodicIrq;
  logic [7:0] periodicDivEvent;
  int err_total, checks_done, cycleNow;

  rtcp_counter i_dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crystalClk, .externalClk, .internalOscClk,
    .overflowWrapEvent, .compareMatchEvent, .periodicDivEvent, .counterIrq, .periodicIrq);
  rtcp_source_model i_sources (.core_clk, .resetn, .internalOscClk, .crystalClk,
    .externalClk);

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cycleNow <= cycleNow + 1;

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic hang(inout int n);
    n++;
    if (n > 3000) begin
      $display("mismatch wait expected answer seen timeout");
      err_total++;
      results();
    end
  endtask

  task automatic axiWrite(input logic [5:0] idx, input logic [31:0] data);
    bit awDone, wDone;
    int n;
    awDone = 0;
    wDone = 0;
    n = 0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      hang(n);
      if (!awDone && s_axi_awready === 1'b1) begin
        awDone = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(awDone && wDone && s_axi_bvalid === 1'b1));
    check("bresp", {30'h0, rtcp_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
  endtask

  task automatic axiRead(input logic [5:0] idx, output logic [31:0] data,
                         output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      hang(n);
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return overflowWrapEvent;
      1: return compareMatchEvent;
      2: return periodicIrq;
      default: return periodicDivEvent[sel-3];
    endcase
  endfunction

  // Cycle stamp of the next change of a watched output to lvl
  task automatic waitEdge(input int sel, input logic lvl, output int at);
    logic prev, cur;
    bit done;
    int n;
    n = 0;
    prev = pick(sel);
    do begin
      @(posedge core_clk);
      hang(n);
      cur = pick(sel);
      done = cur === lvl && prev !== lvl;
      prev = cur;
      at = cycleNow;
    end while (!done);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic checkReset();
    logic [5:0] idx [10];
    logic [31:0] d;
    logic [1:0] r;
    idx = '{rtcp_pkg::CTRL_IDX, rtcp_pkg::STATUS_IDX, rtcp_pkg::IRQ_ENABLE_IDX,
      rtcp_pkg::IRQ_FLAGS_IDX, rtcp_pkg::CALIBRATION_IDX, rtcp_pkg::SOURCE_SELECT_IDX,
      rtcp_pkg::COUNT_IDX, rtcp_pkg::PERIOD_LIMIT_IDX, rtcp_pkg::COMPARE_IDX,
      rtcp_pkg::PERIODIC_CTRL_IDX};
    for (int i = 0; i < 10; i++) begin
      axiRead(idx[i], d, r);
      check("reset value", (idx[i] == rtcp_pkg::PERIOD_LIMIT_IDX) ? 32'hffff : 32'h0, d);
      check("rresp", {30'h0, rtcp_pkg::RESP_OKAY}, {30'h0, r});
    end
    axiRead(6'h05, d, r);
    check("unmapped data", 32'h0, d);
    check("unmapped rresp", {30'h0, rtcp_pkg::RESP_SLVERR}, {30'h0, r});
    check("div events", 32'h0, {24'h0, periodicDivEvent});
  endtask

  task automatic sourceLoop();
    logic [1:0] src [4];
    int gap [4];
    int a, b, c;
    src = '{rtcp_pkg::SRC_INTERNAL_OSC, rtcp_pkg::SRC_INTERNAL_DIV, rtcp_pkg::SRC_CRYSTAL,
      rtcp_pkg::SRC_EXTERNAL};
    gap = '{4, 128, 8, 12};
    axiWrite(rtcp_pkg::PERIOD_LIMIT_IDX, 32'h1);
    axiWrite(rtcp_pkg::IRQ_ENABLE_IDX, 32'h1);
    for (int i = 0; i < 4; i++) begin
      axiWrite(rtcp_pkg::CTRL_IDX, 32'h0);
      axiWrite(rtcp_pkg::SOURCE_SELECT_IDX, {30'h0, src[i]});
      axiWrite(rtcp_pkg::CTRL_IDX, 32'h1);
      waitEdge(0, 1'b1, a);
      waitEdge(0, 1'b0, b);
      waitEdge(0, 1'b1, c);
      check("overflow width", gap[i], b - a);
      check("wrap gap", 2 * gap[i], c - a);
    end
  endtask

  task automatic compareRun();
    logic [31:0] d, e;
    logic [1:0] r;
    int a, b, c;
    axiWrite(rtcp_pkg::CTRL_IDX, 32'h0);
    axiWrite(rtcp_pkg::SOURCE_SELECT_IDX, 32'h0);
    axiWrite(rtcp_pkg::COUNT_IDX, 32'h0);
    axiWrite(rtcp_pkg::PERIOD_LIMIT_IDX, 32'h7);
    axiWrite(rtcp_pkg::COMPARE_IDX, 32'h3);
    axiWrite(rtcp_pkg::IRQ_ENABLE_IDX, 32'h2);
    axiWrite(rtcp_pkg::CTRL_IDX, 32'h11);
    waitEdge(1, 1'b1, a);
    waitEdge(0, 1'b1, b);
    waitEdge(1, 1'b1, c);
    check("compare to wrap", 32'd64, b - a);
    check("compare gap", 32'd128, c - a);
    axiWrite(rtcp_pkg::CTRL_IDX, 32'h10);
    axiRead(rtcp_pkg::IRQ_FLAGS_IDX, d, r);
    check("flags", 32'h3, d);
    check("counter irq", 32'h1, {31'h0, counterIrq});
    axiWrite(rtcp_pkg::IRQ_FLAGS_IDX, 32'h2);
    axiRead(rtcp_pkg::IRQ_FLAGS_IDX, d, r);
    check("flags cleared", 32'h1, d);
    check("counter irq off", 32'h0, {31'h0, counterIrq});
    axiRead(rtcp_pkg::COUNT_IDX, d, r);
    repeat (64) @(posedge core_clk);
    axiRead(rtcp_pkg::COUNT_IDX, e, r);
    check("stopped count", d, e);
  endtask

  task automatic periodicRun();
    logic [31:0] d;
    logic [1:0] r;
    int a, b, c;
    axiWrite(rtcp_pkg::PERIODIC_IRQ_ENABLE_IDX, 32'h1);
    axiWrite(rtcp_pkg::PERIODIC_CTRL_IDX, 32'h11);
    waitEdge(2, 1'b1, a);
    axiWrite(rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX, 32'h1);
    waitEdge(2, 1'b1, a);
    axiWrite(rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX, 32'h1);
    waitEdge(2, 1'b1, b);
    check("periodic gap", 32'd32, b - a);
    waitEdge(3, 1'b1, a);
    waitEdge(3, 1'b0, b);
    waitEdge(3, 1'b1, c);
    check("div event high", 32'd128, b - a);
    check("div event period", 32'd256, c - a);
    axiWrite(rtcp_pkg::PERIODIC_CTRL_IDX, 32'h10);
    axiWrite(rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX, 32'h1);
    axiRead(rtcp_pkg::PERIODIC_IRQ_FLAGS_IDX, d, r);
    check("periodic flag", 32'h0, d);
    check("periodic irq", 32'h0, {31'h0, periodicIrq});
    check("div events off", 32'h0, {24'h0, periodicDivEvent});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    cycleNow = 0;
    err_total = 0;
    checks_done = 0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    checkReset();
    sourceLoop();
    compareRun();
    periodicRun();
    results();
  end
endmodule // rtcp_counter_tb
`default_nettype wire
